// ==== rtl/mms_buffer.sv ====
// small valid/ready buffer holding queued management commands
`timescale 1ns/1ps

module mms_buffer #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // full and empty come straight from the fill count
    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // storage needs no reset, only the pointers and the count do
    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // pointers wrap at depth, count tracks push and pop together
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            if (push && !pop)
            begin
                count <= count + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count <= count - (AW+1)'(1);
            end
        end
    end

endmodule // mms_buffer

// ==== rtl/mms_mgmt_master.sv ====
// management frame master: wishbone registers, link sampling, frame engine
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

// ****************************************************************
// Functional notes
// RULE1: each frame opens with 32 preamble ones, the start field and the opcode, all made by hardware.
// RULE2: the opcode field tells whether the frame reads or writes a phy register.
// RULE3: phy and register address fields come from the software address register.
// RULE4: bits go out serially up to the register address, then on a write a turnaround and the write data.
// RULE5: on a read the phy drives the data bits on the serial input and they land in the read data field.
// RULE6: the output enable is high exactly while the serial output is being driven.
// RULE7: while the scan bit is set, read frames follow one another back to back.
// RULE8: during scanning every finished read refreshes the read data field.
// RULE9: start is 01, read opcode 10, write opcode 01, write turnaround 10, the phy pulls the read turnaround low.
// RULE10: on a read the line is released from the turnaround onward.
// ****************************************************************

module mms_mgmt_master (
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_in,
    input  wire logic                        wb_cyc_in,
    input  wire logic                        wb_stb_in,
    input  wire logic                        wb_we_in,
    input  wire logic [mms_pkg::MMS_ADR_W-1:0] wb_adr_in,
    input  wire logic [3:0]                  wb_sel_in,
    input  wire logic [31:0]                 wb_dat_in,
    output logic [31:0]                      wb_dat_out,
    output logic                             wb_ack_out,
    input  wire logic                        mgmt_clk_in,
    input  wire logic                        mgmt_serial_in,
    output logic                             mgmt_serial_out,
    output logic                             mgmt_out_enable_out
);
    import mms_pkg::*;

    logic [2:0]  clk_sync;
    logic [2:0]  din_sync;
    logic        mdc_level;
    logic        din_level;
    logic        mdc_rise;
    logic        mdc_fall;
    logic        scan_cmd_bit;
    logic [4:0]  phy_addr_value;
    logic [4:0]  phy_reg_addr_value;
    logic [15:0] write_data_field;
    logic [15:0] read_data_field;
    logic [31:0] rd_mux;
    logic [31:0] wmask;
    logic        wb_req;
    logic        push_req;
    logic        wb_take;
    logic        cmd_in_ready;
    logic        cmd_out_valid;
    logic        pop;
    logic        boundary;
    logic        start_frame;
    mms_cmd_s    push_cmd;
    mms_cmd_s    head_cmd;
    mms_cmd_s    next_cmd;
    mms_cmd_s    cur_cmd;
    mms_state_e  state;
    logic [5:0]  bit_cnt;
    logic [63:0] frame_sr;
    logic [15:0] rd_shift;
    logic        oe;

    // ****************************************************************
    // link sampling
    // ****************************************************************

    // three stages; a level counts only once the last two agree
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            clk_sync  <= 3'h0;
            din_sync  <= 3'h0;
            mdc_level <= 1'b0;
            din_level <= 1'b0;
        end
        else
        begin
            clk_sync <= {clk_sync[1:0], mgmt_clk_in};
            din_sync <= {din_sync[1:0], mgmt_serial_in};
            if (clk_sync[1] == clk_sync[2])
                mdc_level <= clk_sync[2];
            if (din_sync[1] == din_sync[2])
                din_level <= din_sync[2];
        end
    end

    // edges count as soon as the last two stages agree, a cycle ahead of the level,
    // so a bit launched on a fall settles before the rise; needs over 4 clocks per half period
    assign mdc_rise = (clk_sync[1] == clk_sync[2]) & clk_sync[2] & ~mdc_level;
    assign mdc_fall = (clk_sync[1] == clk_sync[2]) & ~clk_sync[2] & mdc_level;

    // ****************************************************************
    // wishbone slave
    // ****************************************************************

    // byte lanes become a bit mask for read-modify-write of fields
    assign wmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign wb_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign push_req = wb_req & wb_we_in & (wb_adr_in == MMS_OFS_CMD) & wb_sel_in[0] & wb_dat_in[MMS_CMD_GO_BIT];
    // a go with the buffer full holds off ack until a slot frees up
    assign wb_take  = wb_req & (~push_req | cmd_in_ready);

    // the queued command snapshots the address and data registers
    assign push_cmd = '{is_write: wb_dat_in[MMS_CMD_WRITE_BIT], phy: phy_addr_value,
                        regad: phy_reg_addr_value, data: write_data_field};

    // read multiplexer, unmapped offsets read as zero
    always_comb
    begin
        rd_mux = 32'h0;
        case (wb_adr_in)
            MMS_OFS_CMD:
            begin
                rd_mux[MMS_CMD_SCAN_BIT] = scan_cmd_bit;
                rd_mux[MMS_CMD_BUSY_BIT] = (state == MMS_SHIFT);
                rd_mux[MMS_CMD_FULL_BIT] = ~cmd_in_ready;
            end
            MMS_OFS_ADDR:
            begin
                rd_mux[MMS_ADDR_REG_LSB +: 5] = phy_reg_addr_value;
                rd_mux[MMS_ADDR_PHY_LSB +: 5] = phy_addr_value;
            end
            MMS_OFS_WDATA: rd_mux[15:0] = write_data_field;
            MMS_OFS_RDATA: rd_mux[15:0] = read_data_field;
            default:       rd_mux = 32'h0;
        endcase
    end

    // ack one cycle after the request is taken, dropped the cycle after
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end
        else
        begin
            wb_ack_out <= wb_take;
            wb_dat_out <= (wb_take && !wb_we_in) ? rd_mux : 32'h0;
        end
    end

    // software fields; writes to unmapped offsets are dropped
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scan_cmd_bit       <= 1'b0;
            phy_addr_value     <= MMS_ADDR_RST;
            phy_reg_addr_value <= MMS_ADDR_RST;
            write_data_field   <= MMS_DATA_RST;
        end
        else if (wb_take && wb_we_in)
        begin
            case (wb_adr_in)
                MMS_OFS_CMD:
                    if (wmask[MMS_CMD_SCAN_BIT])
                        scan_cmd_bit <= wb_dat_in[MMS_CMD_SCAN_BIT];
                MMS_OFS_ADDR:
                begin
                    if (wmask[MMS_ADDR_REG_LSB])
                        phy_reg_addr_value <= wb_dat_in[MMS_ADDR_REG_LSB +: 5]; // see RULE3
                    if (wmask[MMS_ADDR_PHY_LSB])
                        phy_addr_value <= wb_dat_in[MMS_ADDR_PHY_LSB +: 5]; // see RULE3
                end
                MMS_OFS_WDATA:
                    write_data_field <= (write_data_field & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
                default:
                    ;
            endcase
        end
    end

    // ****************************************************************
    // command buffer and frame engine
    // ****************************************************************

    // engine pops only at a frame boundary, so a busy line stalls the bus once both buffer slots are full
    mms_buffer #(
        .WIDTH ($bits(mms_cmd_s)),
        .DEPTH (MMS_BUF_DEPTH)
    ) u_cmd_buf (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_req),
        .in_ready_out  (cmd_in_ready),
        .in_data_in    (push_cmd),
        .out_valid_out (cmd_out_valid),
        .out_ready_in  (pop),
        .out_data_out  (head_cmd)
    );

    // queued commands win over scan so software can slip a write in
    assign boundary    = mdc_fall & ((state == MMS_IDLE) | (bit_cnt == MMS_BIT_LAST));
    assign start_frame = boundary & (cmd_out_valid | scan_cmd_bit); // see RULE7
    assign pop         = boundary & cmd_out_valid;
    assign next_cmd    = cmd_out_valid ? head_cmd :
                         '{is_write: 1'b0, phy: phy_addr_value, regad: phy_reg_addr_value, data: MMS_DATA_RST};

    // whole frame as one word, first bit on the line at the top
    function automatic logic [63:0] build_frame(input mms_cmd_s c);
        logic [1:0] op;
        logic [1:0] ta;
        op = c.is_write ? MMS_OP_WRITE : MMS_OP_READ;   // see RULE2 see RULE9
        ta = c.is_write ? MMS_TA_WRITE : MMS_TA_READ;   // see RULE9
        build_frame = {MMS_PREAMBLE, MMS_START, op, c.phy, c.regad, ta,
                       c.is_write ? c.data : MMS_DATA_RST}; // see RULE1 see RULE3 see RULE4
    endfunction

    // one bit per falling link edge; the enable is dropped at the read turnaround
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state    <= MMS_IDLE;
            bit_cnt  <= 6'd0;
            frame_sr <= 64'h0;
            cur_cmd  <= '0;
            oe       <= 1'b0;
        end
        else if (mdc_fall)
        begin
            case (state)
                MMS_IDLE, MMS_SHIFT:
                begin
                    if (start_frame)
                    begin
                        state    <= MMS_SHIFT;
                        bit_cnt  <= 6'd0;
                        frame_sr <= build_frame(next_cmd); // see RULE4
                        cur_cmd  <= next_cmd;
                        oe       <= 1'b1; // see RULE6
                    end
                    else if (boundary)
                    begin
                        state    <= MMS_IDLE;
                        bit_cnt  <= 6'd0;
                        frame_sr <= 64'h0;
                        oe       <= 1'b0; // see RULE6
                    end
                    else
                    begin
                        bit_cnt  <= bit_cnt + 6'd1;
                        frame_sr <= {frame_sr[62:0], 1'b0};
                        oe       <= cur_cmd.is_write | ((bit_cnt + 6'd1) < MMS_BIT_TA); // see RULE10
                    end
                end
                default:
                begin
                    state <= MMS_IDLE;
                    oe    <= 1'b0;
                end
            endcase
        end
    end

    // read data bits sampled on the rising link edge, as the phy drives them
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_shift        <= 16'h0;
            read_data_field <= MMS_DATA_RST;
        end
        else
        begin
            if (mdc_rise && state == MMS_SHIFT && !cur_cmd.is_write && bit_cnt >= MMS_BIT_DATA)
                rd_shift <= {rd_shift[14:0], din_level}; // see RULE5
            if (mdc_fall && state == MMS_SHIFT && !cur_cmd.is_write && bit_cnt == MMS_BIT_LAST)
                read_data_field <= rd_shift; // see RULE5 see RULE8
        end
    end

    // line value while released is a quiet low
    assign mgmt_serial_out     = frame_sr[63];
    assign mgmt_out_enable_out = oe;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence s_in_frame;
        state == MMS_SHIFT;
    endsequence
    sequence s_read_end;
        mdc_fall && state == MMS_SHIFT && !cur_cmd.is_write && bit_cnt == MMS_BIT_LAST;
    endsequence

    property p_preamble;
        s_in_frame ##0 (bit_cnt < MMS_BIT_START) |-> mgmt_serial_out;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble bit not one"); // see RULE1
    property p_start_field;
        s_in_frame ##0 (bit_cnt == MMS_BIT_START) |-> !mgmt_serial_out;
    endproperty
    a_start_field: assert property (p_start_field) else $error("start field wrong"); // see RULE9
    property p_opcode;
        s_in_frame ##0 (bit_cnt == MMS_BIT_OP) |-> mgmt_serial_out == !cur_cmd.is_write;
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode does not match direction"); // see RULE2
    property p_phy_field;
        s_in_frame ##0 (bit_cnt >= MMS_BIT_PHY && bit_cnt < MMS_BIT_REG)
            |-> mgmt_serial_out == cur_cmd.phy[3'(MMS_BIT_REG - 6'd1 - bit_cnt)];
    endproperty
    a_phy_field: assert property (p_phy_field) else $error("phy address bit wrong"); // see RULE3
    property p_write_data;
        s_in_frame ##0 (cur_cmd.is_write && bit_cnt >= MMS_BIT_DATA)
            |-> mgmt_serial_out == cur_cmd.data[4'(MMS_BIT_LAST - bit_cnt)];
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data bit wrong"); // see RULE4
    property p_enable;
        oe == ((state == MMS_SHIFT) && (cur_cmd.is_write || bit_cnt < MMS_BIT_TA));
    endproperty
    a_enable: assert property (p_enable) else $error("output enable out of step"); // see RULE6
    property p_release;
        s_in_frame ##0 (!cur_cmd.is_write && bit_cnt >= MMS_BIT_TA) |-> !mgmt_out_enable_out && !mgmt_serial_out;
    endproperty
    a_release: assert property (p_release) else $error("line driven during read data"); // see RULE10
    property p_capture;
        s_read_end |=> read_data_field == $past(rd_shift);
    endproperty
    a_capture: assert property (p_capture) else $error("read data not captured"); // see RULE5
    property p_scan;
        (boundary && scan_cmd_bit) |=> state == MMS_SHIFT && bit_cnt == 6'd0 && oe ##1 $stable(state);
    endproperty
    a_scan: assert property (p_scan) else $error("scan did not start a frame"); // see RULE7
    property p_scan_update;
        (s_read_end ##0 scan_cmd_bit) |=> state == MMS_SHIFT && read_data_field == $past(rd_shift);
    endproperty
    a_scan_update: assert property (p_scan_update) else $error("scan read not refreshed"); // see RULE8

endmodule // mms_mgmt_master

// ==== rtl/mms_pkg.sv ====
// shared constants and types of the management frame master
package mms_pkg;

    // ****************************************************************
    // register map on the wishbone slave
    // ****************************************************************
    localparam int          MMS_ADR_W        = 8;
    localparam logic [7:0]  MMS_OFS_CMD      = 8'h00;
    localparam logic [7:0]  MMS_OFS_ADDR     = 8'h04;
    localparam logic [7:0]  MMS_OFS_WDATA    = 8'h08;
    localparam logic [7:0]  MMS_OFS_RDATA    = 8'h0c;

    // command register fields
    localparam int          MMS_CMD_GO_BIT    = 0;
    localparam int          MMS_CMD_WRITE_BIT = 1;
    localparam int          MMS_CMD_SCAN_BIT  = 2;
    localparam int          MMS_CMD_BUSY_BIT  = 3;
    localparam int          MMS_CMD_FULL_BIT  = 4;

    // address register fields
    localparam int          MMS_ADDR_REG_LSB = 0;
    localparam int          MMS_ADDR_PHY_LSB = 8;

    // reset values
    localparam logic [4:0]  MMS_ADDR_RST     = 5'h00;
    localparam logic [15:0] MMS_DATA_RST     = 16'h0000;

    // ****************************************************************
    // frame layout, bit 0 is the first bit on the line
    // ****************************************************************
    localparam logic [31:0] MMS_PREAMBLE     = 32'hffffffff;
    localparam logic [1:0]  MMS_START        = 2'b01;
    localparam logic [1:0]  MMS_OP_READ      = 2'b10;
    localparam logic [1:0]  MMS_OP_WRITE     = 2'b01;
    localparam logic [1:0]  MMS_TA_WRITE     = 2'b10;
    localparam logic [1:0]  MMS_TA_READ      = 2'b00;
    localparam logic [5:0]  MMS_BIT_START    = 6'd32;
    localparam logic [5:0]  MMS_BIT_OP       = 6'd34;
    localparam logic [5:0]  MMS_BIT_PHY      = 6'd36;
    localparam logic [5:0]  MMS_BIT_REG      = 6'd41;
    localparam logic [5:0]  MMS_BIT_TA       = 6'd46;
    localparam logic [5:0]  MMS_BIT_DATA     = 6'd48;
    localparam logic [5:0]  MMS_BIT_LAST     = 6'd63;

    // command buffer depth
    localparam int          MMS_BUF_DEPTH    = 2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic        is_write;
        logic [4:0]  phy;
        logic [4:0]  regad;
        logic [15:0] data;
    } mms_cmd_s;

    typedef enum logic {MMS_IDLE, MMS_SHIFT} mms_state_e;

endpackage

// ==== tb/mii_management_serial_master_bench.sv ====
// self-checking bench of the management frame master
`timescale 1ns/1ps

module mii_management_serial_master_bench;
    import mms_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rdq;
    logic        ack, mclk = 1'b0, sdi, sdo, oe;
    logic [63:0] frm;
    logic [15:0] frames, oe_bad, rnd = 16'd69;
    logic [15:0] shadow [32];
    logic [4:0]  ep [3], er [3];
    logic [15:0] ed [3];
    time         t0;
    int          err_count = 0, checks = 0, cyc_n = 0, f0;

    // ****************************************************************
    // clocks, design and far side
    // ****************************************************************
    always #50 clk = ~clk;
    // link clock phase left unrelated to the system clock
    initial
    begin
        #137;
        forever #400 mclk = ~mclk;
    end

    mms_mgmt_master u_dut (.clk_sys_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .mgmt_clk_in(mclk), .mgmt_serial_in(sdi), .mgmt_serial_out(sdo),
        .mgmt_out_enable_out(oe));
    mms_phy_model u_phy (.mgmt_clk_in(mclk), .line_in(sdo), .oe_in(oe), .sdi_out(sdi),
        .frame_out(frm), .frames_out(frames), .oe_bad_out(oe_bad));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // read frames carry zeros once the line is released
    function automatic logic [63:0] xfr(input logic w, input logic [4:0] p, r, input logic [15:0] d);
        return {32'hffffffff, 2'b01, w ? 2'b01 : 2'b10, p, r, w ? 2'b10 : 2'b00, w ? d : 16'h0};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdq = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cmd(input logic w, input logic [4:0] p, r, input logic [15:0] d, input logic sc);
        wb(1'b1, MMS_OFS_ADDR, {19'h0, p, 3'h0, r});
        wb(1'b1, MMS_OFS_WDATA, {16'h0, d});
        wb(1'b1, MMS_OFS_CMD, {29'h0, sc, w, 1'b1});
        if (w)
            shadow[r] = d;
    endtask

    task automatic wait_fr(input int n);
        int t;
        t = int'(frames) + n;
        while (int'(frames) < t) @(posedge clk);
        // read data lands about a link period after the phy has counted the frame
        repeat (10) @(posedge clk);
    endtask

    task automatic stop_test;
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        for (int i = 0; i < 32; i++)
            shadow[i] = {11'h2d3, 5'(i)};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // read-only and unmapped writes must leave everything zero
        wb(1'b1, MMS_OFS_RDATA, 32'hffffffff);
        wb(1'b1, 8'h10, 32'hffffffff);
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(rdq, 64'h0);
        end
        // three writes queued at once; the first is already on the line, so the third finds a slot
        f0 = int'(frames);
        for (int i = 0; i < 3; i++)
        begin
            rnd = nxt(rnd);
            ep[i] = (i == 0) ? 5'h1f : rnd[4:0];
            er[i] = (i == 0) ? 5'h00 : rnd[9:5];
            rnd = nxt(rnd);
            ed[i] = (i == 0) ? 16'h8001 : rnd;
            cmd(1'b1, ep[i], er[i], ed[i], 1'b0);
        end
        for (int i = 0; i < 3; i++)
        begin
            while (int'(frames) < f0 + i + 1) @(posedge clk);
            if (i == 2)
                chk($time - t0, 64'd51200);
            t0 = $time;
            chk(frm, xfr(1'b1, ep[i], er[i], ed[i]));
        end
        wb(1'b0, MMS_OFS_ADDR, 32'h0);
        chk(rdq, {19'h0, ep[2], 3'h0, er[2]});
        // single reads, one of a register just written
        for (int i = 0; i < 3; i++)
        begin
            rnd = nxt(rnd);
            er[0] = (i == 0) ? er[2] : rnd[9:5];
            cmd(1'b0, rnd[4:0], er[0], rnd, 1'b0);
            wait_fr(1);
            chk(frm, xfr(1'b0, rnd[4:0], er[0], 16'h0));
            do wb(1'b0, MMS_OFS_CMD, 32'h0); while (rdq[MMS_CMD_BUSY_BIT] === 1'b1);
            wb(1'b0, MMS_OFS_RDATA, 32'h0);
            chk(rdq, {16'h0, shadow[er[0]]});
        end
        // scan polls one register; a queued write changes it midway
        rnd = nxt(rnd);
        wb(1'b1, MMS_OFS_ADDR, {19'h0, rnd[4:0], 3'h0, rnd[9:5]});
        wb(1'b1, MMS_OFS_CMD, 32'h4);
        wait_fr(1);
        t0 = $time;
        wait_fr(2);
        chk($time - t0, 64'd102400);
        chk(frm, xfr(1'b0, rnd[4:0], rnd[9:5], 16'h0));
        wb(1'b0, MMS_OFS_RDATA, 32'h0);
        chk(rdq, {16'h0, shadow[rnd[9:5]]});
        cmd(1'b1, rnd[4:0], rnd[9:5], ~rnd, 1'b1);
        wait_fr(3);
        wb(1'b0, MMS_OFS_RDATA, 32'h0);
        chk(rdq, {16'h0, ~rnd});
        wb(1'b1, MMS_OFS_CMD, 32'h0);
        wait_fr(1);
        f0 = int'(frames);
        repeat (700) @(posedge clk);
        chk(frames, 16'(f0));
        chk(oe_bad, 64'h0);
        stop_test();
    end
endmodule // mii_management_serial_master_bench

// ==== tb/mms_phy_model.sv ====
// behavioural phy management port answering frames of the master
`timescale 1ns/1ps

module mms_phy_model (
    input  wire logic mgmt_clk_in,
    input  wire logic line_in,
    input  wire logic oe_in,
    output logic      sdi_out,
    output logic [63:0] frame_out,
    output logic [15:0] frames_out,
    output logic [15:0] oe_bad_out
);
    logic [62:0] sh;
    logic [5:0]  cnt = 6'd0;
    logic        rd = 1'b0;
    logic [4:0]  rg = 5'h00;
    logic [15:0] mem [32];

    // ****************************************************************
    // register file and line sampling
    // ****************************************************************
    // register contents start as a known pattern per address
    initial
    begin
        frames_out = 16'h0000;
        oe_bad_out = 16'h0000;
        sdi_out = 1'b1;
        for (int i = 0; i < 32; i++)
            mem[i] = {11'h2d3, 5'(i)};
    end

    // rising edge: sample the line, judge the enable window
    always @(posedge mgmt_clk_in)
    begin
        if (oe_in || cnt != 6'd0)
        begin
            if (((cnt < 6'd46) || !rd) != oe_in || (!oe_in && line_in))
                oe_bad_out <= oe_bad_out + 16'd1;
            sh <= {sh[61:0], line_in};
            cnt <= cnt + 6'd1;
            if (cnt == 6'd35)
                rd <= ({sh[0], line_in} == 2'b10);
            if (cnt == 6'd45)
                rg <= {sh[3:0], line_in};
            if (cnt == 6'd63)
            begin
                frame_out <= {sh, line_in};
                frames_out <= frames_out + 16'd1;
                if (!rd)
                    mem[rg] <= {sh[14:0], line_in};
            end
        end
    end

    // falling edge: turnaround low then data; pull-up level when released
    always @(negedge mgmt_clk_in)
        if (rd && cnt >= 6'd47)
            sdi_out <= (cnt == 6'd47) ? 1'b0 : mem[rg][6'd63 - cnt];
        else
            sdi_out <= 1'b1;
endmodule // mms_phy_model
